//--- cfim_core.sv
// condition flags register with half carry and interrupt mask handling
//
// Summary of operation
// - eight-bit flags register, saved whole, restored whole by pop; interrupt return clears the mask instead
// - add sets half carry on bit3 carry
// - add without a bit3 carry clears it; pop and interrupt return reload it, others keep
// - half carry flag drives its branch tests
// - interrupt entry sets the mask bit
// - mask blocks maskable requests, trap unaffected
// - mask zero services, mask one blocks
// - mask changed only by entry and four instructions: set mask, clear mask, interrupt return, pop
// - requests while masked are held pending
// - interrupt return clears the mask
// - clearing mask services pending requests at the next instruction end
// - entry waits instruction end, flags pushed
// - fixed priority picks among pending requests
// - trap enters regardless of mask
`timescale 1ns/1ps
module cfim_core
  import cfim_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_en,
  input  wire logic [3:0]              op_code,
  input  wire logic                    instr_done,
  input  wire logic [3:0]              alu_a_low,
  input  wire logic [3:0]              alu_b_low,
  input  wire logic                    alu_carry_in,
  input  wire logic                    nzc_we,
  input  wire logic [2:0]              nzc_in,
  input  wire logic [7:0]              pop_data,
  input  wire logic [CFIM_NUM_IRQ-1:0] irq_req,
  input  wire logic                    entry_ack,
  output logic [7:0]                   condition_flags,
  output logic                         branch_if_half_carry,
  output logic                         branch_if_no_half_carry,
  output logic                         branch_if_masked,
  output logic                         branch_if_unmasked,
  output logic                         entry_req,
  output logic                         entry_trap,
  output logic [2:0]                   entry_index,
  output logic [7:0]                   push_data,
  output logic [CFIM_NUM_IRQ-1:0]      pending
);
  cfim_op_type    op;
  cfim_state_type state_q;
  logic [7:0]     flags_img;
  logic [CFIM_NUM_IRQ-1:0] pend_q;
  logic           trap_q;
  logic           any_pend;
  logic [2:0]     sel_idx;
  logic [4:0]     half_sum;
  logic           take_irq;
  logic           take_trap;
  logic [7:0]     push_q;
  logic           entry_trap_q;
  logic [2:0]     entry_index_q;
  logic [CFIM_NUM_IRQ-1:0] clr_vec;
  logic           half_q;
  logic           mask_q;
  logic [2:0]     nzc_q;
  logic           at_boundary;

  // pop and interrupt return both reload the stacked half carry and result flags
  function automatic logic cfim_is_restore(input cfim_op_type op_val);
    cfim_is_restore = (op_val == CFIM_OP_POP) || (op_val == CFIM_OP_INTERRUPT_RETURN_INSTRUCTION);
  endfunction : cfim_is_restore

  // add and add with carry both produce a half carry
  function automatic logic cfim_is_add(input cfim_op_type op_val);
    cfim_is_add = (op_val == CFIM_OP_ADD) || (op_val == CFIM_OP_ADC);
  endfunction : cfim_is_add

  assign op       = cfim_op_type'(op_code);
  assign half_sum = {1'b0, alu_a_low} + {1'b0, alu_b_low}
                  + {4'h0, (op == CFIM_OP_ADC) & alu_carry_in};

  cfim_prio u_prio (
    .req (pend_q),
    .any (any_pend),
    .idx (sel_idx)
  );

  // entries are only taken at an instruction end in the run state
  assign at_boundary = instr_done & (state_q == CFIM_ST_RUN);

  assign take_trap = trap_q & at_boundary;
  assign take_irq  = ~take_trap & any_pend & ~mask_q & at_boundary;

  // register image, upper bits always read as one
  always_comb begin
    flags_img             = CFIM_FIXED_ONE;
    flags_img[CFIM_BIT_H] = half_q;
    flags_img[CFIM_BIT_I] = mask_q;
    flags_img[CFIM_BIT_N] = nzc_q[2];
    flags_img[CFIM_BIT_Z] = nzc_q[1];
    flags_img[CFIM_BIT_C] = nzc_q[0];
  end

  // half carry flag
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      half_q <= CFIM_RESET_VAL[CFIM_BIT_H];
    end else if (clk_en) begin
      if (cfim_is_restore(op)) begin
        half_q <= pop_data[CFIM_BIT_H];
      end else if (cfim_is_add(op)) begin
        half_q <= half_sum[4];
      end
    end
  end

  // interrupt mask bit, entry set wins over software in one cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_q <= CFIM_RESET_VAL[CFIM_BIT_I];
    end else if (clk_en) begin
      if (take_irq || take_trap) begin
        mask_q <= 1'b1;
      end else if (op == CFIM_OP_SETMASK) begin
        mask_q <= 1'b1;
      end else if (op == CFIM_OP_CLRMASK || op == CFIM_OP_INTERRUPT_RETURN_INSTRUCTION) begin
        mask_q <= 1'b0;
      end else if (op == CFIM_OP_POP) begin
        mask_q <= pop_data[CFIM_BIT_I];
      end
    end
  end

  // result flags, a stack restore wins over an alu write
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nzc_q <= CFIM_RESET_VAL[2:0];
    end else if (clk_en) begin
      if (cfim_is_restore(op)) begin
        nzc_q <= pop_data[2:0];
      end else if (nzc_we) begin
        nzc_q <= nzc_in;
      end
    end
  end

  // pending latch, new request wins over clear
  always_comb begin
    clr_vec = '0;
    if (take_irq) begin
      clr_vec[sel_idx] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= '0;
    end else if (clk_en) begin
      pend_q <= (pend_q & ~clr_vec) | irq_req;
    end
  end

  // trap request held until entry
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trap_q <= 1'b0;
    end else if (clk_en) begin
      if (op == CFIM_OP_TRAP) begin
        trap_q <= 1'b1;
      end else if (take_trap) begin
        trap_q <= 1'b0;
      end
    end
  end

  // entry after instruction end, flags captured for push
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q       <= CFIM_ST_RUN;
      push_q        <= CFIM_RESET_VAL;
      entry_trap_q  <= 1'b0;
      entry_index_q <= 3'h0;
    end else if (clk_en) begin
      case (state_q)
        CFIM_ST_RUN: begin
          if (take_trap || take_irq) begin
            state_q       <= CFIM_ST_ENTRY;
            push_q        <= flags_img;
            entry_trap_q  <= take_trap;
            entry_index_q <= take_trap ? 3'h0 : sel_idx;
          end else begin
            push_q <= flags_img;
          end
        end
        CFIM_ST_ENTRY: begin
          if (entry_ack) begin
            state_q <= CFIM_ST_RUN;
          end
        end
        default: state_q <= CFIM_ST_RUN;
      endcase
    end
  end

  assign condition_flags = flags_img;
  assign push_data       = push_q;
  assign entry_req       = (state_q == CFIM_ST_ENTRY);
  assign entry_trap      = entry_trap_q;
  assign entry_index     = entry_index_q;
  assign pending         = pend_q;
  assign branch_if_half_carry    = flags_img[CFIM_BIT_H];
  assign branch_if_no_half_carry = ~flags_img[CFIM_BIT_H];
  assign branch_if_masked        = flags_img[CFIM_BIT_I];
  assign branch_if_unmasked      = ~flags_img[CFIM_BIT_I];
endmodule : cfim_core

//--- cfim_partner.sv
// far side: acknowledges an entry after ack_dly cycles of stacking
`timescale 1ns/1ps
module cfim_partner (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       entry_req,
  input  wire logic [3:0] ack_dly,
  output logic            entry_ack
);
  logic [3:0] wait_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) wait_q <= 4'h0;
    else wait_q <= entry_ack ? 4'h0 : wait_q + 4'(entry_req);
  end
  assign entry_ack = entry_req && wait_q >= ack_dly;
endmodule : cfim_partner

//--- cfim_pkg.sv
// constants for the condition flags and interrupt mask unit
package cfim_pkg;
  localparam int          CFIM_WIDTH     = 8;
  localparam int          CFIM_NUM_IRQ   = 8;
  // field positions in the condition flags register
  localparam int          CFIM_BIT_H     = 4;
  localparam int          CFIM_BIT_I     = 3;
  localparam int          CFIM_BIT_N     = 2;
  localparam int          CFIM_BIT_Z     = 1;
  localparam int          CFIM_BIT_C     = 0;
  // upper bits read as one, mask set out of reset
  localparam logic [7:0]  CFIM_RESET_VAL = 8'hE8;
  localparam logic [7:0]  CFIM_FIXED_ONE = 8'hE0;

  typedef enum logic [3:0] {
    CFIM_OP_NONE    = 4'h0,
    CFIM_OP_ADD     = 4'h1,
    CFIM_OP_ADC     = 4'h2,
    CFIM_OP_SETMASK = 4'h3,
    CFIM_OP_CLRMASK = 4'h4,
    CFIM_OP_INTERRUPT_RETURN_INSTRUCTION    = 4'h5,
    CFIM_OP_POP     = 4'h6,
    CFIM_OP_TRAP    = 4'h7,
    CFIM_OP_OTHER   = 4'h8
  } cfim_op_type;

  typedef enum logic [1:0] {
    CFIM_ST_RUN   = 2'h0,
    CFIM_ST_ENTRY = 2'h1
  } cfim_state_type;
endpackage : cfim_pkg

//--- cfim_prio.sv
// fixed priority picker: lowest index wins
`timescale 1ns/1ps
module cfim_prio
  import cfim_pkg::*;
(
  input  wire logic [CFIM_NUM_IRQ-1:0] req,
  output logic                         any,
  output logic [2:0]                   idx
);
  always_comb begin
    any = 1'b0;
    idx = 3'h0;
    for (int i = CFIM_NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 3'(i);
      end
    end
  end
endmodule : cfim_prio

//--- cfim_sva.sv
// assertions on the ports of the flags and mask unit
`timescale 1ns/1ps
module cfim_sva
  import cfim_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire logic [3:0] op_code,
  input wire logic       instr_done,
  input wire logic [7:0] irq_req,
  input wire logic       entry_ack,
  input wire logic [7:0] condition_flags,
  input wire logic       branch_if_half_carry,
  input wire logic       branch_if_unmasked,
  input wire logic       entry_req,
  input wire logic       entry_trap,
  input wire logic [2:0] entry_index,
  input wire logic [7:0] pending
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] below;
  // requests of higher priority than the chosen index
  assign below = (8'h01 << entry_index) - 8'h01;
  sequence entry_start;
    $rose(entry_req);
  endsequence
  br_map_a: assert property (
    branch_if_half_carry == condition_flags[4]
    && branch_if_unmasked == !condition_flags[3]) else $error("branch map");
  entry_mask_a: assert property (
    entry_start |-> condition_flags[3]
    && (entry_trap || !$past(condition_flags[3]))) else $error("entry mask");
  mask_set_a: assert property (
    clk_en && op_code == CFIM_OP_SETMASK |=> condition_flags[3])
    else $error("mask not set");
  mask_clear_a: assert property (
    clk_en && !instr_done && op_code inside {CFIM_OP_CLRMASK, CFIM_OP_INTERRUPT_RETURN_INSTRUCTION}
    |=> !condition_flags[3]) else $error("mask not cleared");
  req_latch_a: assert property (
    clk_en |=> (pending & $past(irq_req)) == $past(irq_req))
    else $error("request lost");
  entry_take_a: assert property (
    clk_en && instr_done && !entry_req && !condition_flags[3] && |pending
    |=> entry_req) else $error("entry not taken");
  entry_prio_a: assert property (
    (entry_start and !entry_trap) |-> ($past(pending) & below) == 8'h00
    && ($past(pending) & (below + 8'h01)) != 8'h00) else $error("priority");
  entry_ack_a: assert property (
    entry_req && entry_ack && clk_en |=> !entry_req) else $error("ack");
endmodule : cfim_sva
bind cfim_core cfim_sva u_cfim_sva (.*);

//--- tb_condition_flags_interrupt_mask.sv
// self-checking bench for the flags and mask unit
`timescale 1ns/1ps
module tb_condition_flags_interrupt_mask;
  import cfim_pkg::*;
  logic       core_clk, sys_rst, clk_en, instr_done, alu_carry_in, nzc_we;
  logic       entry_ack, entry_req, entry_trap, branch_if_half_carry;
  logic       branch_if_no_half_carry, branch_if_masked, branch_if_unmasked;
  logic [3:0] op_code, alu_a_low, alu_b_low, ack_dly;
  logic [2:0] nzc_in, entry_index;
  logic [7:0] pop_data, irq_req, condition_flags, push_data, pending, br;
  int         n_mismatch, samples_checked, h, i, nzc;
  cfim_core    u_cfim_core (.*);
  cfim_partner u_cfim_partner (.*);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #40us;
    n_mismatch++;
    end_sim();
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic go(input logic [3:0] op, input int n);
    op_code = op;
    repeat (n) @(negedge core_clk);
  endtask : go
  task automatic entry(input logic [7:0] msk, exp, push);
    int k;
    for (k = 0; k < 20 && entry_req !== 1'b1; k++) @(negedge core_clk);
    chk(push_data, push);
    chk({entry_trap, entry_index, condition_flags[3], 3'h0} & msk, exp);
    for (k = 0; k < 20 && entry_req !== 1'b0; k++) @(negedge core_clk);
    chk({7'h0, entry_req}, 8'h00);
  endtask : entry
  initial begin
    {sys_rst, clk_en, instr_done, alu_carry_in, nzc_we, ack_dly} = 9'h100;
    {op_code, alu_a_low, alu_b_low, nzc_in, pop_data, irq_req} = 31'h0;
    i = 1;
    void'($urandom(32'h4FDDD09D));
    repeat (12) @(negedge core_clk);
    sys_rst = 1'b0;
    chk(push_data, CFIM_RESET_VAL);
    chk(pending, 8'h00);
    repeat (300) begin
      chk(condition_flags, {3'h7, h[0], i[0], nzc[2:0]});
      br = {4'h0, branch_if_half_carry, branch_if_no_half_carry,
            branch_if_masked, branch_if_unmasked};
      chk(br, {4'h0, h[0], !h[0], i[0], !i[0]});
      {alu_a_low, alu_b_low, alu_carry_in, nzc_in, pop_data} = 20'($urandom);
      op_code = 4'($urandom % 7);
      clk_en = $urandom % 4 != 0;
      nzc_we = 1'($urandom);
      @(posedge core_clk);
      if (clk_en && op_code inside {CFIM_OP_ADD, CFIM_OP_ADC})
        h = alu_a_low + alu_b_low
            + (op_code == CFIM_OP_ADC && alu_carry_in) > 15;
      if (clk_en && op_code inside {CFIM_OP_SETMASK, CFIM_OP_CLRMASK,
                                    CFIM_OP_INTERRUPT_RETURN_INSTRUCTION})
        i = op_code == CFIM_OP_SETMASK;
      if (clk_en && op_code == CFIM_OP_POP)
        i = pop_data[3];
      if (clk_en && op_code inside {CFIM_OP_INTERRUPT_RETURN_INSTRUCTION, CFIM_OP_POP}) begin
        h = pop_data[4];
        nzc = pop_data[2:0];
      end else if (clk_en && nzc_we)
        nzc = nzc_in;
      @(negedge core_clk);
    end
    chk(condition_flags, {3'h7, h[0], i[0], nzc[2:0]});
    {clk_en, nzc_we, pop_data} = 10'h200;
    go(CFIM_OP_SETMASK, 1);
    irq_req = 8'h24;
    go(CFIM_OP_NONE, 1);
    irq_req = 8'h00;
    instr_done = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(pending, 8'h24);
    chk({7'h0, entry_req}, 8'h00);
    go(CFIM_OP_CLRMASK, 1);
    go(CFIM_OP_NONE, 0);
    entry(8'hFF, 8'h28, {3'h7, h[0], 1'b0, nzc[2:0]});
    chk(pending, 8'h20);
    ack_dly = 4'h5;
    go(CFIM_OP_INTERRUPT_RETURN_INSTRUCTION, 1);
    go(CFIM_OP_NONE, 0);
    entry(8'hFF, 8'h58, 8'hE0);
    go(CFIM_OP_TRAP, 1);
    go(CFIM_OP_NONE, 0);
    entry(8'h88, 8'h88, 8'hE8);
    end_sim();
  end
endmodule : tb_condition_flags_interrupt_mask
